// File: hw/pcg_regs.sv
// Purpose: Control and status registers of a PLL clock generator
// Assumes: Source clocks and lock indicator arrive asynchronously
// Notes: Read data valid one cycle after the read strobe
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pcg_regs (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [pcg_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_oscillator_clock,
  input wire logic i_vco_clock,
  input wire logic i_pll_locked,
  input wire logic i_pll_tracking,
  output logic o_pll_irq,
  output logic o_pll_enable,
  output logic o_base_clock_out,
  output logic o_base_clock_switching,
  output logic o_auto_bandwidth,
  output logic o_tracking_mode,
  output logic [1:0] o_prescale_field,
  output logic [1:0] o_vco_power_range_field,
  output logic [11:0] o_feedback_factor,
  output logic [7:0] o_vco_center_factor,
  output logic [3:0] o_reference_divide_field
);
  //////////////////////////////////////////////////////////////////////////////
  // Register state
  logic pll_irq_enable;
  logic pll_irq_flag;
  logic pll_power_on;
  logic base_clock_select;
  logic [1:0] prescale_field;
  logic [1:0] vco_power_range_field;
  logic auto_bw;
  logic manual_track;
  logic [3:0] feedback_high;
  logic [7:0] feedback_low;
  logic [7:0] vco_center_factor;
  logic [3:0] reference_divide_field;
  logic lock_prev;
  logic vco_driving;

  //////////////////////////////////////////////////////////////////////////////
  // Asynchronous inputs
  logic osc_s;
  logic vco_s;
  logic lock_s;
  logic track_s;
  logic osc_d;
  logic vco_d;

  pcg_sync2 u_sync_osc (
    .i_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_level(i_oscillator_clock),
    .o_level(osc_s)
  );
  pcg_sync2 u_sync_vco (
    .i_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_level(i_vco_clock),
    .o_level(vco_s)
  );
  pcg_sync2 u_sync_lock (
    .i_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_level(i_pll_locked),
    .o_level(lock_s)
  );
  pcg_sync2 u_sync_track (
    .i_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_level(i_pll_tracking),
    .o_level(track_s)
  );

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      osc_d <= 1'b0;
      vco_d <= 1'b0;
    end else begin
      osc_d <= osc_s;
      vco_d <= vco_s;
    end
  end

  wire osc_rise = osc_s & ~osc_d;
  // VCO stays quiet unless the loop is actually enabled
  wire vco_rise = vco_s & ~vco_d & o_pll_enable;

  //////////////////////////////////////////////////////////////////////////////
  // Decode
  wire wr_ctl = i_wr && i_addr == pcg_pkg::OFS_CONTROL;
  wire wr_bw = i_wr && i_addr == pcg_pkg::OFS_BANDWIDTH;
  wire wr_mh = i_wr && i_addr == pcg_pkg::OFS_MULT_HIGH;
  wire wr_ml = i_wr && i_addr == pcg_pkg::OFS_MULT_LOW;
  wire wr_vr = i_wr && i_addr == pcg_pkg::OFS_VCO_RANGE;
  wire wr_rd = i_wr && i_addr == pcg_pkg::OFS_REF_DIV;
  wire rd_ctl = i_rd && i_addr == pcg_pkg::OFS_CONTROL;

  wire center_zero = vco_center_factor == 8'h00;
  // Status under auto; manual value forces mode otherwise
  wire lock_view = auto_bw & lock_s;
  wire track_view = auto_bw ? track_s : manual_track;
  wire lock_toggle = auto_bw && (lock_s != lock_prev);

  wire w_power = i_wdata[pcg_pkg::CTL_POWER_ON];
  wire w_select = i_wdata[pcg_pkg::CTL_BASE_SEL];

  // Power-on refuses to clear while select is set or the switch still runs on the VCO;
  // otherwise a handover back to the oscillator would starve of VCO edges and hang
  wire keep_power = base_clock_select || vco_driving;
  wire next_power_on = (keep_power && !w_power) ? 1'b1 : w_power;
  // Select refuses to set while power is off or center factor is zero
  wire next_select = w_select && pll_power_on && !center_zero;
  wire next_irq_enable = auto_bw & i_wdata[pcg_pkg::CTL_IRQ_EN];

  //////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      pll_irq_enable <= 1'b0;
      pll_power_on <= 1'b1;
      base_clock_select <= 1'b0;
      prescale_field <= pcg_pkg::RST_PRESCALE;
      vco_power_range_field <= pcg_pkg::RST_VCO_POWER;
    end else begin
      if (center_zero) begin
        base_clock_select <= 1'b0;
      end else if (wr_ctl) begin
        base_clock_select <= next_select;
      end
      if (wr_ctl) begin
        pll_power_on <= next_power_on;
        if (auto_bw) begin
          pll_irq_enable <= next_irq_enable;
        end
        // Fields keep value while the loop runs; other bits still update
        if (!pll_power_on) begin
          prescale_field <= i_wdata[pcg_pkg::CTL_PRE_HI:pcg_pkg::CTL_PRE_LO];
          vco_power_range_field <= i_wdata[pcg_pkg::CTL_VPR_HI:pcg_pkg::CTL_VPR_LO];
        end
      end
    end
  end

  // Flag: a toggle in the clearing cycle still wins
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      pll_irq_flag <= 1'b0;
      lock_prev <= 1'b0;
    end else begin
      lock_prev <= lock_s;
      if (!auto_bw) begin
        pll_irq_flag <= 1'b0;
      end else if (lock_toggle) begin
        pll_irq_flag <= 1'b1;
      end else if (rd_ctl) begin
        pll_irq_flag <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bandwidth register
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      auto_bw <= 1'b0;
      manual_track <= 1'b0;
    end else if (wr_bw) begin
      auto_bw <= i_wdata[pcg_pkg::BW_AUTO];
      // Hidden copy survives auto mode untouched
      if (!auto_bw) begin
        manual_track <= i_wdata[pcg_pkg::BW_TRACK];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Multiplier, range and divider registers, all frozen while powered
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      feedback_high <= pcg_pkg::RST_FEEDBACK[11:8];
      feedback_low <= pcg_pkg::RST_FEEDBACK[7:0];
      vco_center_factor <= pcg_pkg::RST_VCO_CENTER;
      reference_divide_field <= pcg_pkg::RST_REF_DIV;
    end else if (!pll_power_on) begin
      if (wr_mh) begin
        feedback_high <= i_wdata[3:0];
      end
      if (wr_ml) begin
        feedback_low <= i_wdata;
      end
      if (wr_vr) begin
        vco_center_factor <= i_wdata;
      end
      if (wr_rd) begin
        reference_divide_field <= i_wdata[3:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path
  wire [7:0] ctl_view = {pll_irq_enable & auto_bw, pll_irq_flag & auto_bw,
                         pll_power_on, base_clock_select, prescale_field,
                         vco_power_range_field};
  wire [7:0] bw_view = {auto_bw, lock_view, track_view, 5'h00};
  logic [7:0] rd_mux;
  always_comb begin
    unique case (i_addr)
      pcg_pkg::OFS_CONTROL: rd_mux = ctl_view;
      pcg_pkg::OFS_BANDWIDTH: rd_mux = bw_view;
      pcg_pkg::OFS_MULT_HIGH: rd_mux = {4'h0, feedback_high};
      pcg_pkg::OFS_MULT_LOW: rd_mux = feedback_low;
      pcg_pkg::OFS_VCO_RANGE: rd_mux = vco_center_factor;
      pcg_pkg::OFS_REF_DIV: rd_mux = {4'h0, reference_divide_field};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock selector
  pcg_clock_switch u_switch (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_select_vco(base_clock_select),
    .i_osc_rise(osc_rise),
    .i_vco_rise(vco_rise),
    .o_active_vco(vco_driving),
    .o_switching(o_base_clock_switching),
    .o_base_clock(o_base_clock_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs to the analog loop; zero feedback and divider codes map to one
  wire [11:0] feedback_raw = {feedback_high, feedback_low};
  assign o_pll_irq = pll_irq_flag & pll_irq_enable & auto_bw;
  assign o_pll_enable = pll_power_on & ~center_zero;
  assign o_auto_bandwidth = auto_bw;
  assign o_tracking_mode = track_view;
  assign o_prescale_field = prescale_field;
  assign o_vco_power_range_field = vco_power_range_field;
  assign o_feedback_factor = (feedback_raw == 12'h000) ? 12'h001 : feedback_raw;
  assign o_vco_center_factor = vco_center_factor;
  assign o_reference_divide_field = (reference_divide_field == 4'h0) ? 4'h1
                                  : reference_divide_field;
endmodule
`default_nettype wire

// File: hw/pcg_pkg.sv
// Purpose: Shared constants for the PLL clock generator register block
// Assumes: Byte-wide registers reached over a plain strobe port
// Notes: Register offsets are local choices
package pcg_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_BANDWIDTH = 3'h1;
  localparam logic [2:0] OFS_MULT_HIGH = 3'h2;
  localparam logic [2:0] OFS_MULT_LOW = 3'h3;
  localparam logic [2:0] OFS_VCO_RANGE = 3'h4;
  localparam logic [2:0] OFS_REF_DIV = 3'h5;
  // Control register fields
  localparam int CTL_IRQ_EN = 7;
  localparam int CTL_IRQ_FLAG = 6;
  localparam int CTL_POWER_ON = 5;
  localparam int CTL_BASE_SEL = 4;
  localparam int CTL_PRE_HI = 3;
  localparam int CTL_PRE_LO = 2;
  localparam int CTL_VPR_HI = 1;
  localparam int CTL_VPR_LO = 0;
  // Bandwidth register fields
  localparam int BW_AUTO = 7;
  localparam int BW_LOCK = 6;
  localparam int BW_TRACK = 5;
  // Reset values
  localparam logic [11:0] RST_FEEDBACK = 12'h040;
  localparam logic [7:0] RST_VCO_CENTER = 8'h40;
  localparam logic [3:0] RST_REF_DIV = 4'h1;
  localparam logic [1:0] RST_PRESCALE = 2'h0;
  localparam logic [1:0] RST_VCO_POWER = 2'h0;
  // Synchroniser stages on each switch side
  localparam int SWITCH_SYNC_STAGES = 3;
endpackage

// File: hw/pcg_sync2.sv
// Purpose: Two-flop level synchroniser
// Assumes: Input is a level from another domain
// Notes: First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module pcg_sync2 (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_level,
  output logic o_level
);
  logic stage1;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      stage1 <= 1'b0;
      o_level <= 1'b0;
    end else begin
      stage1 <= i_level;
      o_level <= stage1;
    end
  end
endmodule
`default_nettype wire

// File: hw/pcg_clock_switch.sv
// Purpose: Glitch-free selector between oscillator and VCO, then divide by two
// Assumes: Both source clocks are sampled as slow signals on the system clock
// Notes: Output holds static while the handover settles
`timescale 1ns/1ps
`default_nettype none
module pcg_clock_switch #(
  parameter int STAGES = pcg_pkg::SWITCH_SYNC_STAGES
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_select_vco,
  input wire logic i_osc_rise,
  input wire logic i_vco_rise,
  output logic o_active_vco,
  output logic o_switching,
  output logic o_base_clock
);
  // Each side counts its own source edges so the wait is in source cycles
  logic [$clog2(STAGES + 1)-1:0] osc_count;
  logic [$clog2(STAGES + 1)-1:0] vco_count;
  logic pending;
  wire want_change = i_select_vco != o_active_vco;
  wire counts_done = (osc_count == ($clog2(STAGES + 1))'(STAGES))
                  && (vco_count == ($clog2(STAGES + 1))'(STAGES));
  wire src_rise = o_active_vco ? i_vco_rise : i_osc_rise;

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      pending <= 1'b0;
      osc_count <= '0;
      vco_count <= '0;
      o_active_vco <= 1'b0;
    end else if (!want_change) begin
      pending <= 1'b0;
      osc_count <= '0;
      vco_count <= '0;
    end else if (counts_done) begin
      o_active_vco <= i_select_vco;
      pending <= 1'b0;
      osc_count <= '0;
      vco_count <= '0;
    end else begin
      pending <= 1'b1;
      if (i_osc_rise && osc_count != ($clog2(STAGES + 1))'(STAGES)) begin
        osc_count <= osc_count + 1'b1;
      end
      if (i_vco_rise && vco_count != ($clog2(STAGES + 1))'(STAGES)) begin
        vco_count <= vco_count + 1'b1;
      end
    end
  end

  // Divide by two on the active source; frozen while a change is wanted
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_base_clock <= 1'b0;
    end else if (!want_change && src_rise) begin
      o_base_clock <= ~o_base_clock;
    end
  end

  assign o_switching = pending | want_change;
endmodule
`default_nettype wire

// File: tb/pcg_regs_asserts.sv
// Purpose: Port-level temporal checks for pcg_regs
// Assumes: One clock, synchronous active-low reset
// Notes: Bound onto every pcg_regs instance
`timescale 1ns/1ps
`default_nettype none
module pcg_regs_asserts (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [pcg_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_pll_irq,
  input wire logic o_pll_enable,
  input wire logic o_base_clock_out,
  input wire logic o_base_clock_switching,
  input wire logic o_auto_bandwidth,
  input wire logic [1:0] o_prescale_field,
  input wire logic [1:0] o_vco_power_range_field,
  input wire logic [11:0] o_feedback_factor,
  input wire logic [7:0] o_vco_center_factor,
  input wire logic [3:0] o_reference_divide_field
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  ////////////////////////////////////////
  AST_IRQ_NEEDS_AUTO: assert property (
    o_pll_irq |-> o_auto_bandwidth) else $error("irq without auto bandwidth");
  AST_CTL_READ_MANUAL: assert property (
    i_rd && i_addr == pcg_pkg::OFS_CONTROL && !o_auto_bandwidth |=> o_rdata[7:6] == 2'b00)
    else $error("enable or flag visible in manual mode");
  AST_IRQ_READ_SHOWS: assert property (
    i_rd && i_addr == pcg_pkg::OFS_CONTROL && o_pll_irq |=> o_rdata[7:6] == 2'b11)
    else $error("irq pending but flag or enable not read");
  AST_LOCK_READ_MANUAL: assert property (
    i_rd && i_addr == pcg_pkg::OFS_BANDWIDTH && !o_auto_bandwidth |=> !o_rdata[6])
    else $error("lock visible in manual mode");
  AST_FIELDS_LOCKED: assert property (
    o_pll_enable |=> $stable(o_prescale_field) && $stable(o_vco_power_range_field))
    else $error("control field changed while powered");
  AST_FACTORS_LOCKED: assert property (
    o_pll_enable |=> $stable(o_feedback_factor) && $stable(o_vco_center_factor)
      && $stable(o_reference_divide_field)) else $error("factor changed while powered");
  AST_CENTER_ZERO_OFF: assert property (
    o_vco_center_factor == 8'h00 |-> !o_pll_enable) else $error("zero center but enabled");
  // Presented factor must follow the stored byte, with zero shown as one
  AST_FEEDBACK_NZ: assert property (
    i_rd && i_addr == pcg_pkg::OFS_MULT_LOW |=> o_rdata == $past(o_feedback_factor[7:0])
      || $past(o_feedback_factor) == 12'h001) else $error("feedback factor disagrees");
  AST_REFDIV_NZ: assert property (
    i_rd && i_addr == pcg_pkg::OFS_REF_DIV |=> $past(o_reference_divide_field)
      == ((o_rdata[3:0] == 4'h0) ? 4'h1 : o_rdata[3:0])) else $error("divider disagrees");
  AST_SWITCH_FROZEN: assert property (
    o_base_clock_switching ##1 o_base_clock_switching |-> $stable(o_base_clock_out))
    else $error("base clock moved during switch");
  AST_SWITCH_BOUNDED: assert property (
    $rose(o_base_clock_switching) |-> ##[1:100] !o_base_clock_switching)
    else $error("source switch did not finish");
endmodule
bind pcg_regs pcg_regs_asserts u_asserts (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_pll_irq(o_pll_irq), .o_pll_enable(o_pll_enable),
  .o_base_clock_out(o_base_clock_out), .o_base_clock_switching(o_base_clock_switching),
  .o_auto_bandwidth(o_auto_bandwidth), .o_prescale_field(o_prescale_field),
  .o_vco_power_range_field(o_vco_power_range_field), .o_feedback_factor(o_feedback_factor),
  .o_vco_center_factor(o_vco_center_factor),
  .o_reference_divide_field(o_reference_divide_field)
);
`default_nettype wire

// File: tb/test_pll_clock_generator_regs.sv
// Purpose: Self-checking bench for pcg_regs
// Assumes: Source clocks run free, unrelated to the system clock
// Notes: Random field traffic from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module test_pll_clock_generator_regs;
  logic i_sys_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [pcg_pkg::ADDR_W-1:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_osc = 1'b0, i_vco = 1'b0, i_lock = 1'b0, i_trk = 1'b1;
  logic o_irq, o_en, o_bclk, o_sw, o_auto, o_trk;
  logic [7:0] o_rdata, o_vc;
  logic [1:0] o_pre, o_vpr;
  logic [11:0] o_fb;
  logic [3:0] o_rdiv;
  int error_cnt = 0, checked = 0, seed = 39;
  always #10 i_sys_clk = ~i_sys_clk;
  always #70 i_osc = ~i_osc;
  always #31 i_vco = ~i_vco;
  pcg_regs DUT (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_oscillator_clock(i_osc), .i_vco_clock(i_vco), .i_pll_locked(i_lock),
    .i_pll_tracking(i_trk), .o_pll_irq(o_irq), .o_pll_enable(o_en),
    .o_base_clock_out(o_bclk), .o_base_clock_switching(o_sw), .o_auto_bandwidth(o_auto),
    .o_tracking_mode(o_trk), .o_prescale_field(o_pre), .o_vco_power_range_field(o_vpr),
    .o_feedback_factor(o_fb), .o_vco_center_factor(o_vc), .o_reference_divide_field(o_rdiv));
  ////////////////////////////////////////
  task automatic end_of_test;
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [11:0] nz1(input logic [11:0] v);
    return (v == 12'h000) ? 12'h001 : v;
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input string nm, input logic [2:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk(nm, {4'h0, o_rdata}, {4'h0, e});
  endtask
  task automatic factors_at_reset;
    rdc("mult_hi", pcg_pkg::OFS_MULT_HIGH, 8'h00);
    rdc("mult_lo", pcg_pkg::OFS_MULT_LOW, 8'h40);
    rdc("vco_rng", pcg_pkg::OFS_VCO_RANGE, 8'h40);
    rdc("ref_div", pcg_pkg::OFS_REF_DIV, 8'h01);
  endtask
  // Polls off the edge so combinational flags have settled
  task automatic settle_and_rate(input string nm, input int per);
    int n;
    logic last;
    n = 0;
    for (int k = 0; k < 100 && o_sw !== 1'b0; k++) #20;
    chk("switching", o_sw, 12'h000);
    last = o_bclk;
    repeat (140) begin
      #20;
      n += int'(o_bclk !== last);
      last = o_bclk;
    end
    chk(nm, 12'(n >= 2800 / per - 2 && n <= 2800 / per + 2), 12'h001);
  endtask
  task automatic lock_to(input logic v);
    @(posedge i_sys_clk);
    i_lock <= v;
    repeat (6) @(posedge i_sys_clk);
    #1;
  endtask
  initial begin
    repeat (10000) @(posedge i_sys_clk);
    error_cnt++;
    end_of_test;
  end
  ////////////////////////////////////////
  initial begin
    logic [31:0] x;
    logic [1:0] vpr;
    repeat (20) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    rdc("ctl_rst", pcg_pkg::OFS_CONTROL, 8'h20);
    rdc("bw_rst", pcg_pkg::OFS_BANDWIDTH, 8'h00);
    factors_at_reset;
    wr(3'h7, 8'hff);
    rdc("unmapped", 3'h7, 8'h00);
    rdc("unmapped", 3'h6, 8'h00);
    // Powered: fields refuse, select still takes
    wr(pcg_pkg::OFS_CONTROL, 8'hfe);
    rdc("ctl_lockd", pcg_pkg::OFS_CONTROL, 8'h30);
    for (int r = 2; r < 6; r++) wr(3'(r), 8'h0a);
    factors_at_reset;
    settle_and_rate("vco_rate", 62);
    wr(pcg_pkg::OFS_CONTROL, 8'h00);
    rdc("ctl_keep_on", pcg_pkg::OFS_CONTROL, 8'h20);
    settle_and_rate("osc_rate", 140);
    wr(pcg_pkg::OFS_CONTROL, 8'h00);
    wr(pcg_pkg::OFS_CONTROL, 8'h10);
    rdc("ctl_no_sel", pcg_pkg::OFS_CONTROL, 8'h00);
    for (int i = 0; i < 40; i++) begin
      x = (i == 0 || i == 39) ? 32'h0 : (i == 1) ? 32'hffffffff : $random(seed);
      vpr = (x[3:2] == 2'h3) ? 2'h2 : x[3:2];
      wr(pcg_pkg::OFS_CONTROL, {4'h0, x[1:0], vpr});
      wr(pcg_pkg::OFS_MULT_HIGH, {4'h0, x[7:4]});
      wr(pcg_pkg::OFS_MULT_LOW, x[15:8]);
      wr(pcg_pkg::OFS_VCO_RANGE, x[23:16]);
      wr(pcg_pkg::OFS_REF_DIV, {4'h0, x[27:24]});
      rdc("ctl_fld", pcg_pkg::OFS_CONTROL, {4'h0, x[1:0], vpr});
      rdc("mult_hi", pcg_pkg::OFS_MULT_HIGH, {4'h0, x[7:4]});
      rdc("vco_rng", pcg_pkg::OFS_VCO_RANGE, x[23:16]);
      chk("vc", {4'h0, o_vc}, {4'h0, x[23:16]});
      chk("fb", o_fb, nz1({x[7:4], x[15:8]}));
      chk("rdiv", o_rdiv, nz1({8'h00, x[27:24]}));
      chk("pre", {10'h0, o_pre}, {10'h0, x[1:0]});
      chk("vpr", {10'h0, o_vpr}, {10'h0, vpr});
    end
    // Manual tracking is clear here before power-on
    wr(pcg_pkg::OFS_CONTROL, 8'h20);
    chk("en_zero_ctr", o_en, 12'h000);
    wr(pcg_pkg::OFS_CONTROL, 8'h30);
    rdc("ctl_zero_ctr", pcg_pkg::OFS_CONTROL, 8'h20);
    wr(pcg_pkg::OFS_CONTROL, 8'h00);
    wr(pcg_pkg::OFS_VCO_RANGE, 8'h40);
    wr(pcg_pkg::OFS_CONTROL, 8'h20);
    chk("en_on", o_en, 12'h001);
    // Lock flag and interrupt
    wr(pcg_pkg::OFS_BANDWIDTH, 8'h20);
    rdc("bw_man", pcg_pkg::OFS_BANDWIDTH, 8'h20);
    // Still a manual write, so tracking stays set; lock position written zero
    wr(pcg_pkg::OFS_BANDWIDTH, 8'ha0);
    rdc("bw_auto", pcg_pkg::OFS_BANDWIDTH, 8'ha0);
    chk("auto", o_auto, 12'h001);
    // Tracking bit written clear under auto must not reach the hidden copy
    wr(pcg_pkg::OFS_BANDWIDTH, 8'h80);
    @(posedge i_sys_clk) i_trk <= 1'b0;
    lock_to(1'b0);
    rdc("bw_acq", pcg_pkg::OFS_BANDWIDTH, 8'h80);
    chk("trk_acq", o_trk, 12'h000);
    @(posedge i_sys_clk) i_trk <= 1'b1;
    lock_to(1'b0);
    wr(pcg_pkg::OFS_CONTROL, 8'ha0);
    rdc("ctl_ie", pcg_pkg::OFS_CONTROL, 8'ha0);
    lock_to(1'b1);
    chk("irq_set", o_irq, 12'h001);
    rdc("bw_lock", pcg_pkg::OFS_BANDWIDTH, 8'he0);
    rdc("ctl_flag", pcg_pkg::OFS_CONTROL, 8'he0);
    chk("irq_clr", o_irq, 12'h000);
    rdc("ctl_clr", pcg_pkg::OFS_CONTROL, 8'ha0);
    lock_to(1'b0);
    chk("irq_unlock", o_irq, 12'h001);
    wr(pcg_pkg::OFS_CONTROL, 8'h20);
    chk("irq_masked", o_irq, 12'h000);
    rdc("ctl_masked", pcg_pkg::OFS_CONTROL, 8'h60);
    lock_to(1'b1);
    wr(pcg_pkg::OFS_BANDWIDTH, 8'h00);
    rdc("ctl_man", pcg_pkg::OFS_CONTROL, 8'h20);
    rdc("bw_restore", pcg_pkg::OFS_BANDWIDTH, 8'h20);
    chk("trk_mode", o_trk, 12'h001);
    wr(pcg_pkg::OFS_CONTROL, 8'ha0);
    rdc("ctl_ie_man", pcg_pkg::OFS_CONTROL, 8'h20);
    end_of_test;
  end
endmodule
`default_nettype wire
